/* hdl/ppm_pkg.sv */
/*
 * ppm_pkg: constants, enumerations and carriers shared by the copper port
 * power and link manager, its property checks, partner model and bench.
 * assumes a single 100 MHz reference clock and 16-bit management registers.
 */
package ppm_pkg;

   // reference clock and long intervals
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned ED_BURST_S = 5;
   localparam int unsigned WAKE_PERIOD_S = 1;
   localparam int unsigned ED_BURST_CYC = ED_BURST_S * CLK_HZ;
   localparam int unsigned WAKE_PERIOD_CYC = WAKE_PERIOD_S * CLK_HZ;

   // basic control register field positions
   localparam int unsigned CTL_RESET_BIT = 15;
   localparam int unsigned CTL_SPEED_LSB_BIT = 13;
   localparam int unsigned CTL_ANEG_EN_BIT = 12;
   localparam int unsigned CTL_PDOWN_BIT = 11;
   localparam int unsigned CTL_RESTART_BIT = 9;
   localparam int unsigned CTL_DUPLEX_BIT = 8;
   localparam int unsigned CTL_SPEED_MSB_BIT = 6;

   // port-specific control register: energy-detect mode field
   localparam int unsigned PSC_ED_HI_BIT = 9;
   localparam int unsigned PSC_ED_LO_BIT = 8;
   localparam logic [1:0] ED_MODE_PLAIN = 2'h2;
   localparam logic [1:0] ED_MODE_ENHANCED = 2'h3;

   // values after reset, before the hardware defaults are loaded
   localparam logic [15:0] CTL_RESET_VAL = 16'h1000;
   localparam logic [15:0] PSC_RESET_VAL = 16'h0000;
   localparam logic [15:0] NP_RESET_VAL = 16'h0000;

   // forced speed select encoding {msb, lsb}
   localparam logic [1:0] FSEL_10 = 2'h0;
   localparam logic [1:0] FSEL_100 = 2'h1;
   localparam logic [1:0] FSEL_1000 = 2'h2;

   typedef enum logic [1:0] {
      SPD_10,
      SPD_100,
      SPD_1000
   } ppm_speed_e;

   typedef enum logic [1:0] {
      PWR_D0,
      PWR_D0U,
      PWR_D3
   } ppm_pwr_e;

   // resolved or forced link operating point
   typedef struct packed {
      ppm_speed_e speed;
      logic full_duplex;
      logic master;
   } ppm_link_s;

   // advertised abilities sent in the base and next pages
   typedef struct packed {
      logic adv_1000;
      logic adv_100;
      logic adv_10;
      logic pause;
      logic np_able;
   } ppm_adv_s;

endpackage

/* hdl/ppm_timer.sv */
/*
 * ppm_timer: interval counter for the pulse burst and the wake-pulse period.
 * assumes start wins over run, and done is a one-cycle registered pulse.
 */
`timescale 1ns/100ps
module ppm_timer #(
   parameter int unsigned CYCLES = 100
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // control
   input wire logic start_i,
   input wire logic run_i,
   // status
   output logic done_o
);
   localparam logic [31:0] LAST = 32'(CYCLES - 1);

   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic done_reg;
   logic at_last;

   assign at_last = (cnt_reg == LAST);
   // wraps so that a free-running period needs no restart
   assign cnt_next = (start_i || !run_i || at_last) ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;

   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         cnt_reg <= 32'h0000_0000;
         done_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         done_reg <= run_i && !start_i && at_last;
      end
   end

   assign done_o = done_reg;

endmodule // ppm_timer

/* hdl/ppm_link_power.sv */
/*
 * ppm_link_power: link setup (negotiation, parallel detect, forced) and power
 * modes (energy detect, power-down, low-state speed reduction) for one port.
 * assumes synchronous line activity levels and a separate page exchange engine.
 */
`timescale 1ns/100ps

module ppm_link_power
   import ppm_pkg::*;
#(
   parameter int unsigned BURST_CYCLES = ppm_pkg::ED_BURST_CYC,
   parameter int unsigned WAKE_CYCLES = ppm_pkg::WAKE_PERIOD_CYC
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // hardware default values for the control registers
   input wire logic [15:0] hw_ctl_default_i,
   input wire logic [15:0] hw_psc_default_i,
   // management writes
   input wire logic ctl_wr_i,
   input wire logic [15:0] ctl_wdata_i,
   input wire logic psc_wr_i,
   input wire logic [15:0] psc_wdata_i,
   input wire logic np_tx_wr_i,
   input wire logic [15:0] np_tx_wdata_i,
   input wire logic local_np_able_i,
   input wire logic force_master_i,
   // host power state
   input wire ppm_pkg::ppm_pwr_e mac_pwr_i,
   input wire logic link_required_i,
   input wire logic phy_speed_mgmt_enable_i,
   // line activity from the front end and negotiation engine
   input wire logic rx_energy_i,
   input wire logic rx_mlt3_i,
   input wire logic rx_nlp_i,
   input wire logic an_done_i,
   input wire ppm_pkg::ppm_link_s an_result_i,
   input wire logic lp_np_able_i,
   input wire logic np_rx_valid_i,
   input wire logic [15:0] np_rx_data_i,
   input wire logic link_ok_i,
   // register views
   output logic [15:0] ctl_o,
   output logic [15:0] psc_o,
   output logic [15:0] np_tx_o,
   output logic [15:0] np_rx_o,
   // line control
   output logic tx_flp_o,
   output logic tx_nlp_o,
   output logic pdown_o,
   output logic ed_monitor_o,
   output logic mdix_auto_o,
   output logic np_exchange_o,
   output ppm_pkg::ppm_adv_s adv_o,
   // link status
   output logic link_up_o,
   output ppm_pkg::ppm_link_s link_o,
   output logic link_pd_o,
   output logic pd_fault_o,
   output logic speed_reduced_o
);
   typedef enum logic [2:0] {
      ST_LOAD,
      ST_PDOWN,
      ST_ANEG,
      ST_ED_MON,
      ST_FORCED,
      ST_LINK
   } ppm_state_e;

   ppm_state_e state_reg, state_next;
   logic [15:0] ctl_reg, psc_reg, np_tx_reg, np_rx_reg;
   logic slow_reg, slow_next, mac_low_reg, pd_reg, pd_next, fault_reg;
   ppm_link_s link_reg, link_next;
   logic tx_flp_reg, tx_nlp_reg, pdown_reg, ed_mon_reg, mdix_reg, np_ex_reg, link_up_reg;
   ppm_adv_s adv_reg;

   // decoded control
   logic [1:0] ed_mode, fsel;
   logic ed_enabled, ed_enhanced, aneg_en, soft_reset, restart;
   ppm_link_s forced_link;
   logic mac_low, low_no_link, low_entry_link, d0_return, want_pdown;
   logic pd_single, pd_both, start_aneg, burst_done, wake_done, wake_run;

   assign ed_mode = {psc_reg[PSC_ED_HI_BIT], psc_reg[PSC_ED_LO_BIT]};
   assign ed_enabled = (ed_mode == ED_MODE_PLAIN) || (ed_mode == ED_MODE_ENHANCED);
   assign ed_enhanced = (ed_mode == ED_MODE_ENHANCED);
   assign aneg_en = ctl_reg[CTL_ANEG_EN_BIT];
   assign soft_reset = ctl_reg[CTL_RESET_BIT];
   assign restart = ctl_reg[CTL_RESTART_BIT];
   assign fsel = {ctl_reg[CTL_SPEED_MSB_BIT], ctl_reg[CTL_SPEED_LSB_BIT]};

   // forced operating point: speed, duplex and master from management
   assign forced_link.speed = (fsel == FSEL_1000) ? SPD_1000 :
                              (fsel == FSEL_100) ? SPD_100 : SPD_10;
   assign forced_link.full_duplex = ctl_reg[CTL_DUPLEX_BIT];
   assign forced_link.master = force_master_i;

   // host power events
   assign mac_low = (mac_pwr_i == PWR_D3) || (mac_pwr_i == PWR_D0U);
   assign low_no_link = mac_low && !link_required_i;
   assign low_entry_link = mac_low && !mac_low_reg && link_required_i;
   assign d0_return = (mac_pwr_i == PWR_D0) && mac_low_reg;
   assign want_pdown = low_no_link || ctl_reg[CTL_PDOWN_BIT];

   // parallel detection: exactly one legacy signalling seen
   assign pd_single = rx_mlt3_i ^ rx_nlp_i;
   assign pd_both = rx_mlt3_i && rx_nlp_i;

   // the burst timer restarts on every entry to negotiation
   assign start_aneg = (state_next == ST_ANEG) && (state_reg != ST_ANEG);
   assign wake_run = (state_reg == ST_ED_MON) && ed_enhanced;

   ppm_timer #(.CYCLES(BURST_CYCLES)) u_burst_timer (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .start_i(start_aneg),
      .run_i(state_reg == ST_ANEG), .done_o(burst_done)
   );

   ppm_timer #(.CYCLES(WAKE_CYCLES)) u_wake_timer (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .start_i(1'b0),
      .run_i(wake_run), .done_o(wake_done)
   );

   // link state sequencing
   always_comb
   begin
      state_next = state_reg;
      slow_next = slow_reg;
      pd_next = pd_reg;
      link_next = link_reg;
      unique case (state_reg)
         ST_LOAD:
         begin
            state_next = aneg_en ? ST_ANEG : ST_FORCED;
         end
         ST_PDOWN:
         begin
            // no detection and no pulses until the host is back in D0
            if (!want_pdown && (mac_pwr_i == PWR_D0 || !mac_low))
            begin
               slow_next = 1'b0;
               state_next = aneg_en ? ST_ANEG : ST_FORCED;
            end
         end
         ST_ANEG:
         begin
            if (!aneg_en)
            begin
               state_next = ST_FORCED;
            end
            else if (an_done_i)
            begin
               link_next = an_result_i;
               pd_next = 1'b0;
               state_next = ST_LINK;
            end
            else if (pd_single)
            begin
               // legacy partner: half duplex whatever it is forced to
               link_next.speed = rx_mlt3_i ? SPD_100 : SPD_10;
               link_next.full_duplex = 1'b0;
               link_next.master = 1'b0;
               pd_next = 1'b1;
               state_next = ST_LINK;
            end
            else if (burst_done)
            begin
               state_next = ed_enabled ? ST_ED_MON : ST_ANEG;
            end
         end
         ST_ED_MON:
         begin
            if (rx_energy_i || !aneg_en)
            begin
               state_next = aneg_en ? ST_ANEG : ST_FORCED;
            end
         end
         ST_FORCED:
         begin
            link_next = forced_link;
            pd_next = 1'b0;
            if (aneg_en)
            begin
               state_next = ST_ANEG;
            end
         end
         ST_LINK:
         begin
            if (!link_ok_i)
            begin
               state_next = ST_ANEG;
            end
            else if (low_entry_link && phy_speed_mgmt_enable_i
                     && link_reg.speed == SPD_1000)
            begin
               slow_next = 1'b1;
               state_next = ST_ANEG;
            end
            else if (d0_return && slow_reg)
            begin
               slow_next = 1'b0;
               state_next = ST_ANEG;
            end
            // speed management off: the link simply stays as it is
         end
      endcase
      // power-down and port reset override every state except ST_LOAD
      if (state_reg != ST_LOAD)
      begin
         if (want_pdown)
         begin
            state_next = ST_PDOWN;
         end
         else if (soft_reset || (restart && aneg_en))
         begin
            state_next = aneg_en ? ST_ANEG : ST_FORCED;
         end
      end
      // a fresh session forgets how the last link came up
      if (state_next == ST_ANEG)
         pd_next = 1'b0;
   end

   // control registers: hardware defaults first, management afterwards
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         ctl_reg <= CTL_RESET_VAL;
         psc_reg <= PSC_RESET_VAL;
         np_tx_reg <= NP_RESET_VAL;
      end
      else if (state_reg == ST_LOAD)
      begin
         // writes in the load cycle are dropped so the defaults stand
         ctl_reg <= hw_ctl_default_i;
         psc_reg <= hw_psc_default_i;
      end
      else
      begin
         if (ctl_wr_i)
            ctl_reg <= ctl_wdata_i;
         else
         begin
            // reset and restart are self-clearing commands
            ctl_reg[CTL_RESET_BIT] <= 1'b0;
            ctl_reg[CTL_RESTART_BIT] <= 1'b0;
         end
         if (psc_wr_i)
            psc_reg <= psc_wdata_i;
         if (np_tx_wr_i)
            np_tx_reg <= np_tx_wdata_i;
      end
   end

   // state, status and received next page
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         state_reg <= ST_LOAD;
         slow_reg <= 1'b0;
         mac_low_reg <= 1'b0;
         pd_reg <= 1'b0;
         fault_reg <= 1'b0;
         link_reg <= '0;
         np_rx_reg <= NP_RESET_VAL;
      end
      else
      begin
         state_reg <= state_next;
         slow_reg <= slow_next;
         mac_low_reg <= mac_low;
         pd_reg <= pd_next;
         link_reg <= link_next;
         // fault holds while both signallings persist during negotiation
         fault_reg <= (state_next == ST_ANEG) && pd_both;
         if (np_rx_valid_i && np_ex_reg)
         begin
            np_rx_reg <= np_rx_data_i;
         end
      end
   end

   // registered line controls
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         tx_flp_reg <= 1'b0;
         tx_nlp_reg <= 1'b0;
         pdown_reg <= 1'b0;
         ed_mon_reg <= 1'b0;
         mdix_reg <= 1'b0;
         np_ex_reg <= 1'b0;
         link_up_reg <= 1'b0;
         adv_reg <= '0;
      end
      else
      begin
         // fast pulses stop once a single legacy signalling is seen
         tx_flp_reg <= (state_next == ST_ANEG) && !pd_single;
         tx_nlp_reg <= wake_done && ed_enhanced && (state_next == ST_ED_MON);
         pdown_reg <= (state_next == ST_PDOWN);
         ed_mon_reg <= (state_next == ST_ED_MON);
         mdix_reg <= aneg_en && (state_next != ST_FORCED);
         np_ex_reg <= local_np_able_i && lp_np_able_i && (state_next == ST_ANEG);
         link_up_reg <= ((state_next == ST_LINK) || (state_next == ST_FORCED))
                        && link_ok_i;
         adv_reg.adv_1000 <= !slow_next;
         adv_reg.adv_100 <= 1'b1;
         adv_reg.adv_10 <= 1'b1;
         adv_reg.pause <= 1'b1;
         adv_reg.np_able <= local_np_able_i;
      end
   end

   assign ctl_o = ctl_reg;
   assign psc_o = psc_reg;
   assign np_tx_o = np_tx_reg;
   assign np_rx_o = np_rx_reg;
   assign tx_flp_o = tx_flp_reg;
   assign tx_nlp_o = tx_nlp_reg;
   assign pdown_o = pdown_reg;
   assign ed_monitor_o = ed_mon_reg;
   assign mdix_auto_o = mdix_reg;
   assign np_exchange_o = np_ex_reg;
   assign adv_o = adv_reg;
   assign link_up_o = link_up_reg;
   assign link_o = link_reg;
   assign link_pd_o = pd_reg;
   assign pd_fault_o = fault_reg;
   assign speed_reduced_o = slow_reg;

endmodule // ppm_link_power

/* dv/ppm_link_power_properties.sv */
/* ppm_link_power_properties: port checks for the link power manager.
   assumes a bind into ppm_link_power, one clock, sync active-low reset. */
`timescale 1ns/100ps
module ppm_link_power_properties
   import ppm_pkg::*;
#(
   parameter int unsigned BURST_CYCLES = 50,
   parameter int unsigned WAKE_CYCLES = 20
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // watched inputs
   input wire logic local_np_able_i,
   input wire logic lp_np_able_i,
   input wire logic np_rx_valid_i,
   // watched outputs
   input wire logic [15:0] ctl_o,
   input wire logic [15:0] psc_o,
   input wire logic [15:0] np_rx_o,
   input wire logic tx_flp_o,
   input wire logic tx_nlp_o,
   input wire logic pdown_o,
   input wire logic ed_monitor_o,
   input wire logic mdix_auto_o,
   input wire logic np_exchange_o,
   input wire ppm_pkg::ppm_adv_s adv_o,
   input wire logic link_up_o,
   input wire ppm_pkg::ppm_link_s link_o,
   input wire logic link_pd_o,
   input wire logic pd_fault_o,
   input wire logic speed_reduced_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   int unsigned flp_run;
   int unsigned mon_run;
   logic mon_seen;
   wire enh_mode = psc_o[9:8] == ED_MODE_ENHANCED;
   // run counters; the burst bound allows one cycle for the registered done pulse
   always_ff @(posedge clock_i)
   begin
      flp_run <= (reset_n_i && tx_flp_o && psc_o[9]) ? flp_run + 1 : 0;
      mon_run <= tx_nlp_o ? 0 : mon_run + 1;
      mon_seen <= reset_n_i && ed_monitor_o && enh_mode && (tx_nlp_o || mon_seen);
   end
   AST_BURST_BOUND: assert property (tx_flp_o |-> flp_run <= BURST_CYCLES)
      else $error("fast pulse burst too long");
   AST_WAKE_GAP: assert property (mon_seen && ed_monitor_o
      |-> (tx_nlp_o ? mon_run == WAKE_CYCLES - 1 : mon_run < WAKE_CYCLES - 1))
      else $error("wake pulse spacing wrong");
   AST_PLAIN_QUIET: assert property (!enh_mode && !$past(enh_mode) |-> !tx_nlp_o)
      else $error("wake pulse outside enhanced mode");
   AST_PDOWN_QUIET: assert property (pdown_o
      |-> !tx_flp_o && !tx_nlp_o && !ed_monitor_o && !link_up_o)
      else $error("activity in power-down");
   AST_REDUCED_ADV: assert property (speed_reduced_o
      |-> !adv_o.adv_1000 && adv_o.adv_100 && adv_o.adv_10)
      else $error("reduced advertisement wrong");
   AST_RESTORE_ADV: assert property ($fell(speed_reduced_o) && !pdown_o |-> adv_o.adv_1000)
      else $error("gigabit not advertised again");
   AST_FORCED_MDIX: assert property (link_up_o && !ctl_o[12] |-> !mdix_auto_o)
      else $error("crossover active on forced link");
   AST_PD_HALF: assert property (link_pd_o
      |-> !link_o.full_duplex && !link_o.master && link_o.speed != SPD_1000)
      else $error("parallel link not 10/100 half");
   AST_FAULT_FLP: assert property (pd_fault_o |-> tx_flp_o && !link_pd_o)
      else $error("fault without fast pulses");
   AST_NP_BOTH: assert property (np_exchange_o
      |-> $past(local_np_able_i) && $past(lp_np_able_i))
      else $error("next page exchange without both able");
   AST_NP_CAPTURE: assert property (!$stable(np_rx_o) |-> $past(np_rx_valid_i))
      else $error("received page changed without valid");
endmodule // ppm_link_power_properties

bind ppm_link_power ppm_link_power_properties #(
   .BURST_CYCLES(BURST_CYCLES),
   .WAKE_CYCLES(WAKE_CYCLES)
) u_ppm_link_power_properties (
   .clock_i(clock_i), .reset_n_i(reset_n_i), .local_np_able_i(local_np_able_i),
   .lp_np_able_i(lp_np_able_i), .np_rx_valid_i(np_rx_valid_i), .ctl_o(ctl_o),
   .psc_o(psc_o), .np_rx_o(np_rx_o), .tx_flp_o(tx_flp_o), .tx_nlp_o(tx_nlp_o),
   .pdown_o(pdown_o), .ed_monitor_o(ed_monitor_o), .mdix_auto_o(mdix_auto_o),
   .np_exchange_o(np_exchange_o), .adv_o(adv_o), .link_up_o(link_up_o), .link_o(link_o),
   .link_pd_o(link_pd_o), .pd_fault_o(pd_fault_o), .speed_reduced_o(speed_reduced_o)
);

/* dv/ppm_link_partner.sv */
/* ppm_link_partner: remote copper partner seen through the front end.
   assumes mode 0 silent, 1 energy only, 2 pulses, 3 MLT3, 4 both, 5 negotiating. */
`timescale 1ns/100ps
module ppm_link_partner
   import ppm_pkg::*;
(
   // clock and our fast pulses
   input wire logic clock_i,
   input wire logic tx_flp_i,
   // behaviour chosen by the bench
   input wire logic [2:0] mode_i,
   input wire ppm_pkg::ppm_link_s res_i,
   input wire logic np_able_i,
   input wire logic [15:0] np_data_i,
   // line and negotiation view
   output logic rx_energy_o,
   output logic rx_mlt3_o,
   output logic rx_nlp_o,
   output logic an_done_o,
   output ppm_pkg::ppm_link_s an_result_o,
   output logic lp_np_able_o,
   output logic np_valid_o,
   output logic [15:0] np_data_o,
   output logic link_ok_o
);
   logic [4:0] flp_cnt = 5'h00;
   logic flp_q = 1'b0;
   logic linked = 1'b0;
   logic done_q = 1'b0;
   // a fresh burst from us drops the old link, as a real peer retrains
   always_ff @(posedge clock_i)
   begin
      flp_q <= tx_flp_i;
      flp_cnt <= (mode_i != 3'd5 || !tx_flp_i) ? 5'h00 : flp_cnt + (flp_cnt != 5'h1F);
      np_valid_o <= mode_i == 3'd5 && tx_flp_i && flp_cnt == 5'h04;
      done_q <= mode_i == 3'd5 && tx_flp_i && flp_cnt == 5'h09;
      linked <= mode_i == 3'd5 && (done_q || (linked && !(tx_flp_i && !flp_q)));
   end
   assign an_done_o = done_q;
   // result and page lines carry junk outside their strobes
   assign an_result_o = done_q ? res_i : ppm_link_s'(~res_i);
   assign np_data_o = np_valid_o ? np_data_i : ~np_data_i;
   assign rx_energy_o = mode_i != 3'd0;
   assign rx_nlp_o = mode_i == 3'd2 || mode_i == 3'd4;
   assign rx_mlt3_o = mode_i == 3'd3 || mode_i == 3'd4;
   assign lp_np_able_o = np_able_i;
   assign link_ok_o = mode_i == 3'd2 || mode_i == 3'd3 || linked;
endmodule // ppm_link_partner

/* dv/tb_ppm_link_power.sv */
/* tb_ppm_link_power: directed bench for the link power manager.
   assumes shortened burst and wake counts and the partner model. */
`timescale 1ns/100ps
module tb_ppm_link_power;
   import ppm_pkg::*;
   localparam int unsigned BURST = 50;
   localparam int unsigned WAKE = 20;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic ctl_wr = 1'b0, psc_wr = 1'b0, np_wr = 1'b0, loc_np = 1'b1, frc_master = 1'b1;
   logic link_req = 1'b0, spd_mgmt = 1'b1, lp_np = 1'b1;
   logic [15:0] wdata = 16'h0000, np_data = 16'hC3A5, d16;
   logic [1:0] fs;
   ppm_pwr_e mac_pwr = PWR_D0;
   logic [2:0] mode = 3'd0;
   ppm_link_s res = '0, an_res, link_o;
   ppm_adv_s adv_o;
   logic energy, mlt3, nlp, an_done, lp_able, np_valid, link_ok;
   logic [15:0] np_rx_data, ctl_o, psc_o, np_tx_o, np_rx_o;
   logic tx_flp_o, tx_nlp_o, pdown_o, ed_monitor_o, mdix_auto_o, np_exchange_o;
   logic link_up_o, link_pd_o, pd_fault_o, speed_reduced_o;
   int errors = 0, n_checks = 0, i, k, cnt;

   always #5 clock_i = ~clock_i;

   ppm_link_power #(.BURST_CYCLES(BURST), .WAKE_CYCLES(WAKE)) u_ppm_link_power (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .hw_ctl_default_i(16'h1000),
      .hw_psc_default_i(16'h0300), .ctl_wr_i(ctl_wr), .ctl_wdata_i(wdata),
      .psc_wr_i(psc_wr), .psc_wdata_i(wdata), .np_tx_wr_i(np_wr), .np_tx_wdata_i(wdata),
      .local_np_able_i(loc_np), .force_master_i(frc_master), .mac_pwr_i(mac_pwr),
      .link_required_i(link_req), .phy_speed_mgmt_enable_i(spd_mgmt), .rx_energy_i(energy),
      .rx_mlt3_i(mlt3), .rx_nlp_i(nlp), .an_done_i(an_done), .an_result_i(an_res),
      .lp_np_able_i(lp_able), .np_rx_valid_i(np_valid), .np_rx_data_i(np_rx_data),
      .link_ok_i(link_ok), .ctl_o(ctl_o), .psc_o(psc_o), .np_tx_o(np_tx_o),
      .np_rx_o(np_rx_o), .tx_flp_o(tx_flp_o), .tx_nlp_o(tx_nlp_o), .pdown_o(pdown_o),
      .ed_monitor_o(ed_monitor_o), .mdix_auto_o(mdix_auto_o), .np_exchange_o(np_exchange_o),
      .adv_o(adv_o), .link_up_o(link_up_o), .link_o(link_o), .link_pd_o(link_pd_o),
      .pd_fault_o(pd_fault_o), .speed_reduced_o(speed_reduced_o));

   ppm_link_partner u_ppm_link_partner (
      .clock_i(clock_i), .tx_flp_i(tx_flp_o), .mode_i(mode), .res_i(res),
      .np_able_i(lp_np), .np_data_i(np_data), .rx_energy_o(energy), .rx_mlt3_o(mlt3),
      .rx_nlp_o(nlp), .an_done_o(an_done), .an_result_o(an_res), .lp_np_able_o(lp_able),
      .np_valid_o(np_valid), .np_data_o(np_rx_data), .link_ok_o(link_ok));

   // the extra nanosecond lets the edge's register updates land before sampling
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic report(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      report({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      report(got, exp);
   endtask

   // sel 0 basic control, 1 port-specific control, 2 next page transmit
   task automatic wr(input int sel, input logic [15:0] d);
      @(posedge clock_i);
      wdata <= d;
      ctl_wr <= sel == 0;
      psc_wr <= sel == 1;
      np_wr <= sel == 2;
      @(posedge clock_i);
      {ctl_wr, psc_wr, np_wr} <= 3'b000;
      #1;
   endtask

   task automatic wait_up();
      for (k = 0; k < 60 && !link_up_o; k++) tick(1);
   endtask

   task automatic close_out();
      $display("TB: %0d errors, %0d checks", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clock_i);
      reset_n_i <= 1'b1;
      tick(3);
      chk16(ctl_o, 16'h1000);
      chk16(psc_o, 16'h0300);
      chk1(tx_flp_o, 1'b1);
      chk16({11'h000, adv_o}, 16'h001F);
      for (k = 0; k < 2 * BURST && !ed_monitor_o; k++) tick(1);
      chk1(ed_monitor_o, 1'b1);
      chk1(tx_flp_o, 1'b0);
      for (k = 0; k < WAKE + 4 && !tx_nlp_o; k++) tick(1);
      chk1(tx_nlp_o, 1'b1);
      mode <= 3'd1;
      tick(2);
      chk1(tx_flp_o, 1'b1);
      mode <= 3'd0;
      wr(1, 16'h0200);
      for (k = 0; k < 2 * BURST && !ed_monitor_o; k++) tick(1);
      cnt = 0;
      for (k = 0; k < 3 * WAKE; k++)
      begin
         tick(1);
         cnt += tx_nlp_o;
      end
      chk16(cnt[15:0], 16'h0000);
      chk1(ed_monitor_o, 1'b1);
      // a forced peer shows only pulses or MLT3 whatever its duplex
      for (i = 2; i < 4; i++)
      begin
         mode <= 3'(i);
         for (k = 0; k < 20 && !link_pd_o; k++) tick(1);
         chk1(link_up_o, 1'b1);
         chk1(tx_flp_o, 1'b0);
         chk1(link_pd_o, 1'b1);
         chk16({12'h000, link_o}, {12'h000, (i == 2) ? SPD_10 : SPD_100, 2'b00});
         mode <= 3'd0;
         tick(3);
         chk1(tx_flp_o, 1'b1);
      end
      mode <= 3'd4;
      tick(3);
      chk1(pd_fault_o, 1'b1);
      chk1(tx_flp_o, 1'b1);
      res <= '{SPD_1000, 1'b1, 1'b1};
      mode <= 3'd5;
      wait_up();
      chk16({12'h000, link_o}, 16'h000B);
      chk1(mdix_auto_o, 1'b1);
      link_req <= 1'b1;
      mac_pwr <= PWR_D3;
      tick(2);
      chk1(speed_reduced_o, 1'b1);
      chk1(adv_o.adv_1000, 1'b0);
      res <= '{SPD_100, 1'b1, 1'b0};
      wait_up();
      chk16({12'h000, link_o}, 16'h0006);
      mac_pwr <= PWR_D0;
      tick(2);
      chk1(adv_o.adv_1000, 1'b1);
      chk1(tx_flp_o, 1'b1);
      res <= '{SPD_1000, 1'b1, 1'b1};
      wait_up();
      spd_mgmt <= 1'b0;
      mac_pwr <= PWR_D3;
      tick(3);
      chk1(tx_flp_o, 1'b0);
      chk16({12'h000, link_o}, 16'h000B);
      spd_mgmt <= 1'b1;
      link_req <= 1'b0;
      mode <= 3'd1;
      for (i = 0; i < 2; i++)
      begin
         mac_pwr <= (i == 0) ? PWR_D3 : PWR_D0U;
         tick(3);
         chk1(pdown_o, 1'b1);
         chk1(ed_monitor_o | tx_flp_o, 1'b0);
         mac_pwr <= PWR_D0;
         tick(2);
         chk1(tx_flp_o, 1'b1);
         chk16({11'h000, adv_o}, 16'h001F);
      end
      // force_master_i is tied high, so forced gigabit here must come up master
      for (i = 0; i < 6; i++)
      begin
         fs = (i < 2) ? FSEL_10 : (i < 4) ? FSEL_100 : FSEL_1000;
         d16 = 16'h8000;
         d16[CTL_SPEED_LSB_BIT] = fs[0];
         d16[CTL_SPEED_MSB_BIT] = fs[1];
         d16[CTL_DUPLEX_BIT] = i[0];
         wr(0, d16);
         chk16(ctl_o, d16);
         tick(1);
         chk16(ctl_o, d16 & 16'h7FFF);
         tick(1);
         chk16({13'h0000, link_o[3:1]}, {13'h0000, 2'(i / 2), i[0]});
         chk1(mdix_auto_o | tx_flp_o, 1'b0);
         if (i > 3) chk1(link_o.master, 1'b1);
      end
      wr(0, 16'h0800);
      tick(1);
      chk1(pdown_o, 1'b1);
      wr(0, 16'h1200);
      tick(1);
      chk16(ctl_o, 16'h1000);
      chk1(tx_flp_o, 1'b1);
      mode <= 3'd5;
      wr(2, 16'h2A5C);
      chk16(np_tx_o, 16'h2A5C);
      tick(2);
      chk1(np_exchange_o, 1'b1);
      wait_up();
      chk16(np_rx_o, 16'hC3A5);
      lp_np <= 1'b0;
      np_data <= 16'h0F0F;
      wr(0, 16'h1200);
      tick(2);
      chk1(np_exchange_o, 1'b0);
      wait_up();
      chk16(np_rx_o, 16'hC3A5);
      close_out();
   end

   // whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clock_i);
      errors++;
      close_out();
   end
endmodule // tb_ppm_link_power
